// ---- src/catb_map.svh ----
// Purpose: Register indices, field positions and counts of the time base
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef CATB_MAP_SVH
`define CATB_MAP_SVH
`define CATB_ADDR_W 12
`define CATB_IDX_CTRL_FLAGS 8'hd8
`define CATB_IDX_MODE_CFG 8'hd9
`define CATB_IDX_COUNT_LO 8'he9
`define CATB_IDX_COUNT_HI 8'hf9
`define CATB_IDX_IRQ_STATUS 8'hf0
`define CATB_IDX_IRQ_CLEAR 8'hf1
`define CATB_IDX_IRQ_ENABLE 8'hf2
`define CATB_BIT_OVF_FLAG 7
`define CATB_BIT_RUN 6
`define CATB_BIT_IDLE_STOP 7
`define CATB_BIT_WDT_EN 6
`define CATB_BIT_SRC_HI 2
`define CATB_BIT_SRC_LO 1
`define CATB_BIT_OVF_IEN 0
`define CATB_BIT_STAT_OVF 5
`define CATB_MODULES 5
`define CATB_PIN_EXT_COUNT 2
`define CATB_PIN_MODULE0 3
`define CATB_DIV_SLOW 4'hc
`define CATB_DIV_SLOW_DS 4'h6
`define CATB_DIV_FAST 4'h4
`define CATB_DIV_FAST_DS 4'h2
`define CATB_COUNT_MAX 16'hffff
`endif

// ---- src/catb_pkg.sv ----
// Purpose: Types shared by the time base and its bench
// Assumes: Constants come from the map header
// Notes: Reset image of the whole state lives here
package catb_pkg;
  `include "catb_map.svh"

  typedef enum logic [1:0] {
    CATB_SRC_DIV_SLOW = 2'h0,
    CATB_SRC_DIV_FAST = 2'h1,
    CATB_SRC_TIMER0 = 2'h2,
    CATB_SRC_EXT_PIN = 2'h3
  } catb_src_e;

  typedef enum logic [1:0] {
    CATB_BUS_IDLE = 2'b01,
    CATB_BUS_DONE = 2'b10
  } catb_bus_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`CATB_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } catb_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } catb_apb_rsp_s;

  typedef struct packed {
    catb_bus_e bus;
    logic err;
    logic [7:0] rdata;
    logic overflow_flag;
    logic run_control;
    logic [`CATB_MODULES-1:0] module_event_flag;
    logic idle_stop_select;
    logic module4_watchdog_enable;
    catb_src_e count_source;
    logic overflow_irq_enable;
    logic [`CATB_MODULES-1:0] module_irq_enable;
    logic [15:0] count;
    logic [3:0] presc;
    logic tick;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic t0_d;
    logic [7:0] p1_out;
    logic [7:0] p1_oe;
    logic [`CATB_MODULES-1:0] module_pin_in;
    logic irq;
  } catb_state_s;

  localparam catb_state_s CATB_STATE_RST = '{
    bus: CATB_BUS_IDLE,
    count_source: CATB_SRC_DIV_SLOW,
    default: '0
  };
endpackage

// ---- src/catb_time_base.sv ----
// Purpose: Shared 16-bit time base of the counter array, APB registers
// Assumes: clk is the oscillator; pins are synchronous to clk
// Notes: Capture/compare modules sit outside and strobe their flags in
//
// Overview of operation
// - Two-bit source selects divider, timer0, pin
// - One 16-bit counter shared by five modules
// - Module and overflow requests share one interrupt
// - Modules may request interrupt on each event
// - Port 1 bit 2 counts, bits 3-7 modules
// - Idle-stop bit halts counting during CPU idle
// - Watchdog enable bit drives module 4 watchdog
// - Overflow interrupt enable gates the overflow request
// - Counter advances only while run bit set
// - Rollover sets overflow flag; software-only clear
// - Module flags set by hardware, software clears
// - Count readable as high and low bytes
// - Module flag interrupts only when enabled
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`include "catb_map.svh"
module catb_time_base (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input catb_pkg::catb_apb_req_s apb_req,
  output catb_pkg::catb_apb_rsp_s apb_rsp,
  // Count sources and CPU state
  input wire logic timer0_overflow,
  input wire logic double_speed_mode,
  input wire logic cpu_idle,
  // Capture/compare modules
  input wire logic [4:0] module_event_set,
  input wire logic [4:0] module_pin_out,
  input wire logic [4:0] module_pin_oe,
  output logic [4:0] module_pin_in,
  output logic [15:0] count_value,
  output logic count_tick,
  output logic module4_watchdog_enable,
  // Port 1
  input wire logic [7:0] p1_in,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  // Interrupt
  output logic irq
);
  import catb_pkg::*;

  catb_state_s st_reg;
  catb_state_s st_next;
  logic [3:0] div;
  logic src_pulse;
  logic tick;
  logic ovf_evt;
  logic mapped;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic wr_en;
  logic [7:0] p1_out_mux;
  logic [7:0] p1_oe_mux;

  function automatic logic hit(input logic [`CATB_ADDR_W-1:0] addr,
                               input logic [7:0] idx);
    return addr == {2'h0, idx, 2'h0};
  endfunction

  function automatic logic [3:0] divider(input catb_src_e src,
                                         input logic ds);
    if (src == CATB_SRC_DIV_FAST) begin
      return ds ? `CATB_DIV_FAST_DS : `CATB_DIV_FAST;
    end
    return ds ? `CATB_DIV_SLOW_DS : `CATB_DIV_SLOW;
  endfunction

  // Ordinary I/O keeps the pin unless the module drives it
  assign p1_out_mux[`CATB_PIN_MODULE0-1:0] =
    gpio_out[`CATB_PIN_MODULE0-1:0];
  assign p1_oe_mux[`CATB_PIN_MODULE0-1:0] =
    gpio_oe[`CATB_PIN_MODULE0-1:0];
  genvar g;
  generate
    for (g = 0; g < `CATB_MODULES; g++) begin : g_pin
      assign p1_out_mux[`CATB_PIN_MODULE0+g] = module_pin_oe[g] ?
        module_pin_out[g] : gpio_out[`CATB_PIN_MODULE0+g];
      assign p1_oe_mux[`CATB_PIN_MODULE0+g] =
        module_pin_oe[g] | gpio_oe[`CATB_PIN_MODULE0+g];
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    // Two-stage synchroniser, edge taken from later stages
    st_next.ext_s1 = p1_in[`CATB_PIN_EXT_COUNT];
    st_next.ext_s2 = st_reg.ext_s1;
    st_next.ext_s3 = st_reg.ext_s2;
    st_next.t0_d = timer0_overflow;
    st_next.module_pin_in = p1_in[`CATB_PIN_MODULE0+:`CATB_MODULES];
    st_next.p1_out = p1_out_mux;
    st_next.p1_oe = p1_oe_mux;

    // Prescaler free-runs; wrap on >= so a divider change never hangs
    div = divider(st_reg.count_source, double_speed_mode);
    if (st_reg.presc >= div - 4'h1) begin
      st_next.presc = 4'h0;
    end else begin
      st_next.presc = st_reg.presc + 4'h1;
    end
    unique case (st_reg.count_source)
      CATB_SRC_DIV_SLOW, CATB_SRC_DIV_FAST: begin
        src_pulse = st_reg.presc >= div - 4'h1;
      end
      CATB_SRC_TIMER0: begin
        src_pulse = timer0_overflow & ~st_reg.t0_d;
      end
      CATB_SRC_EXT_PIN: begin
        // Falling edge; rate limit kept by the source
        src_pulse = st_reg.ext_s3 & ~st_reg.ext_s2;
      end
    endcase
    tick = st_reg.run_control & src_pulse &
      ~(st_reg.idle_stop_select & cpu_idle);
    ovf_evt = tick & (st_reg.count == `CATB_COUNT_MAX);
    if (tick) begin
      st_next.count = st_reg.count + 16'h1;
    end
    st_next.tick = tick;

    // Register file
    wbyte = apb_req.pwdata[7:0];
    mapped = hit(apb_req.paddr, `CATB_IDX_CTRL_FLAGS) |
      hit(apb_req.paddr, `CATB_IDX_MODE_CFG) |
      hit(apb_req.paddr, `CATB_IDX_COUNT_LO) |
      hit(apb_req.paddr, `CATB_IDX_COUNT_HI) |
      hit(apb_req.paddr, `CATB_IDX_IRQ_STATUS) |
      hit(apb_req.paddr, `CATB_IDX_IRQ_CLEAR) |
      hit(apb_req.paddr, `CATB_IDX_IRQ_ENABLE);
    rd_byte = 8'h00;
    if (hit(apb_req.paddr, `CATB_IDX_CTRL_FLAGS)) begin
      rd_byte[`CATB_BIT_OVF_FLAG] = st_reg.overflow_flag;
      rd_byte[`CATB_BIT_RUN] = st_reg.run_control;
      rd_byte[`CATB_MODULES-1:0] = st_reg.module_event_flag;
    end
    if (hit(apb_req.paddr, `CATB_IDX_MODE_CFG)) begin
      rd_byte[`CATB_BIT_IDLE_STOP] = st_reg.idle_stop_select;
      rd_byte[`CATB_BIT_WDT_EN] = st_reg.module4_watchdog_enable;
      rd_byte[`CATB_BIT_SRC_HI:`CATB_BIT_SRC_LO] = st_reg.count_source;
      rd_byte[`CATB_BIT_OVF_IEN] = st_reg.overflow_irq_enable;
    end
    if (hit(apb_req.paddr, `CATB_IDX_COUNT_LO)) begin
      rd_byte = st_reg.count[7:0];
    end
    if (hit(apb_req.paddr, `CATB_IDX_COUNT_HI)) begin
      rd_byte = st_reg.count[15:8];
    end
    if (hit(apb_req.paddr, `CATB_IDX_IRQ_STATUS)) begin
      rd_byte[`CATB_BIT_STAT_OVF] = st_reg.overflow_flag;
      rd_byte[`CATB_MODULES-1:0] = st_reg.module_event_flag;
    end
    if (hit(apb_req.paddr, `CATB_IDX_IRQ_ENABLE)) begin
      rd_byte[`CATB_BIT_STAT_OVF] = st_reg.overflow_irq_enable;
      rd_byte[`CATB_MODULES-1:0] = st_reg.module_irq_enable;
    end

    // Answer one cycle after the access phase; data taken from a register
    // so the master sees stable read data at its sampling edge
    wr_en = 1'b0;
    unique case (st_reg.bus)
      CATB_BUS_IDLE: begin
        if (apb_req.psel & apb_req.penable) begin
          st_next.bus = CATB_BUS_DONE;
          st_next.err = ~mapped;
          st_next.rdata = rd_byte;
        end
      end
      CATB_BUS_DONE: begin
        st_next.bus = CATB_BUS_IDLE;
        wr_en = apb_req.pwrite & ~st_reg.err;
      end
    endcase

    // Reserved bits are dropped on write and read as zero
    if (wr_en & hit(apb_req.paddr, `CATB_IDX_CTRL_FLAGS)) begin
      st_next.overflow_flag = wbyte[`CATB_BIT_OVF_FLAG];
      st_next.run_control = wbyte[`CATB_BIT_RUN];
      st_next.module_event_flag = wbyte[`CATB_MODULES-1:0];
    end
    if (wr_en & hit(apb_req.paddr, `CATB_IDX_MODE_CFG)) begin
      st_next.idle_stop_select = wbyte[`CATB_BIT_IDLE_STOP];
      st_next.module4_watchdog_enable = wbyte[`CATB_BIT_WDT_EN];
      st_next.count_source =
        catb_src_e'(wbyte[`CATB_BIT_SRC_HI:`CATB_BIT_SRC_LO]);
      st_next.overflow_irq_enable = wbyte[`CATB_BIT_OVF_IEN];
    end
    if (wr_en & hit(apb_req.paddr, `CATB_IDX_IRQ_CLEAR)) begin
      st_next.overflow_flag = st_next.overflow_flag &
        ~wbyte[`CATB_BIT_STAT_OVF];
      st_next.module_event_flag = st_next.module_event_flag &
        ~wbyte[`CATB_MODULES-1:0];
    end
    if (wr_en & hit(apb_req.paddr, `CATB_IDX_IRQ_ENABLE)) begin
      st_next.overflow_irq_enable = wbyte[`CATB_BIT_STAT_OVF];
      st_next.module_irq_enable = wbyte[`CATB_MODULES-1:0];
    end
    // Hardware set wins over any clear in the same cycle
    st_next.overflow_flag = st_next.overflow_flag | ovf_evt;
    st_next.module_event_flag = st_next.module_event_flag |
      module_event_set;
    st_next.irq =
      (st_next.overflow_flag & st_next.overflow_irq_enable) |
      |(st_next.module_event_flag & st_next.module_irq_enable);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= CATB_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign apb_rsp.pready = st_reg.bus == CATB_BUS_DONE;
  assign apb_rsp.pslverr = (st_reg.bus == CATB_BUS_DONE) & st_reg.err;
  assign apb_rsp.prdata = {24'h000000, st_reg.rdata};
  assign count_value = st_reg.count;
  assign count_tick = st_reg.tick;
  assign module4_watchdog_enable = st_reg.module4_watchdog_enable;
  assign module_pin_in = st_reg.module_pin_in;
  assign p1_out = st_reg.p1_out;
  assign p1_oe = st_reg.p1_oe;
  assign irq = st_reg.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_INC: assert property (
    tick |=> st_reg.count == $past(st_reg.count) + 16'h1)
    else $error("count did not step by one");
  AST_RUN_STOP: assert property (
    !st_reg.run_control |=> $stable(st_reg.count))
    else $error("count moved while stopped");
  AST_IDLE: assert property (
    st_reg.idle_stop_select && cpu_idle |=> $stable(st_reg.count))
    else $error("count moved during gated idle");
  AST_OVF: assert property (
    tick && st_reg.count == `CATB_COUNT_MAX |=>
      st_reg.overflow_flag && st_reg.count == 16'h0000)
    else $error("rollover did not set overflow flag");
  AST_MOD_FLAG: assert property (
    module_event_set[0] |=> st_reg.module_event_flag[0])
    else $error("module event lost");
  AST_IRQ_OVF: assert property (
    st_reg.overflow_flag && !st_reg.overflow_irq_enable &&
      (st_reg.module_event_flag & st_reg.module_irq_enable) == 5'h00
      |-> !irq)
    else $error("interrupt without enabled source");
  AST_IRQ_MOD: assert property (
    module_event_set[0] && st_reg.module_irq_enable[0] |=> irq)
    else $error("enabled module event gave no interrupt");
  AST_EXT_EDGE: assert property (
    st_reg.count_source == CATB_SRC_EXT_PIN && st_reg.run_control &&
      !(st_reg.idle_stop_select && cpu_idle) &&
      st_reg.ext_s3 && !st_reg.ext_s2 |-> tick ##1 !tick)
    else $error("pin edge not counted once");
  AST_PIN: assert property (
    module_pin_oe[4] |=> p1_oe[7] && p1_out[7] == $past(module_pin_out[4]))
    else $error("module pin not on port");
  AST_WDT: assert property (
    wr_en && hit(apb_req.paddr, `CATB_IDX_MODE_CFG) |=>
      module4_watchdog_enable == $past(wbyte[`CATB_BIT_WDT_EN]))
    else $error("watchdog enable not written");
  AST_APB: assert property (
    apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("bus answer late");
  AST_ERR: assert property (
    apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("error without ready");
  AST_TICK_OUT: assert property (
    tick |=> count_tick)
    else $error("count tick not shown");
  AST_RUN_GATE: assert property (
    tick |-> st_reg.run_control)
    else $error("tick while stopped");
  AST_PRESC: assert property (
    st_reg.presc < `CATB_DIV_SLOW)
    else $error("prescaler out of range");

  // Flags fall only by a software write
  AST_OVF_HOLD: assert property (
    st_reg.overflow_flag && !wr_en |=> st_reg.overflow_flag)
    else $error("overflow flag cleared by hardware");
  AST_FLAG_HOLD: assert property (
    !wr_en |=> (st_reg.module_event_flag &
      $past(st_reg.module_event_flag)) == $past(st_reg.module_event_flag))
    else $error("module flag cleared by hardware");

  COV_ROLL: cover property (tick && st_reg.count == `CATB_COUNT_MAX);
  COV_EXT: cover property (tick && st_reg.count_source == CATB_SRC_EXT_PIN);
  COV_T0: cover property (tick && st_reg.count_source == CATB_SRC_TIMER0);
  COV_IRQ: cover property ($rose(irq));
  COV_IDLE: cover property (cpu_idle && st_reg.idle_stop_select);
endmodule

// ---- testbench/catb_pin_model.sv ----
// Purpose: Far-side pins, timer 0 overflow and external count input
// Assumes: Bench calls burst between other stimulus
// Notes: Count pin idles high as a pulled-up port line
`timescale 1ns/10ps
module catb_pin_model (
  // Clock
  input wire logic clk,
  // Event sources
  output logic timer0_overflow,
  output logic ext_count
);
  initial begin
    timer0_overflow = 1'b0;
    ext_count = 1'b1;
  end

  // Levels of gap clocks; gap >= 4 keeps under osc/8
  task automatic burst(input logic ext, input int n, input int gap);
    repeat (n) begin
      if (ext) ext_count <= 1'b0;
      else timer0_overflow <= 1'b1;
      repeat (gap) @(posedge clk);
      if (ext) ext_count <= 1'b1;
      else timer0_overflow <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule

// ---- testbench/catb_time_base_tb.sv ----
// Purpose: Self-checking bench of the counter time base
// Assumes: APB answer comes with one wait state
// Notes: Overflow by rollover needs 64k counts, so only set by software
`timescale 1ns/10ps
`include "catb_map.svh"
module catb_time_base_tb;
  import catb_pkg::*;
  logic clk = 1'b0, rst = 1'b1, dsm = 1'b0, idle = 1'b0, t0, ext;
  logic [4:0] mev = 5'h0, mpo = 5'h0, mpoe = 5'h0, mpi;
  logic [7:0] gout = 8'h0, goe = 8'h0, pins = 8'h0, p1o, p1e;
  logic [15:0] cnt, c0;
  logic tick, wde, irq, er;
  logic [31:0] q;
  catb_apb_req_s req = '0;
  catb_apb_rsp_s rsp;
  int fails = 0, check_count = 0;

  always #20 clk = ~clk;

  catb_pin_model i_catb_pin_model (.clk(clk), .timer0_overflow(t0),
    .ext_count(ext));
  catb_time_base i_catb_time_base (.clk(clk), .rst(rst), .apb_req(req),
    .apb_rsp(rsp), .timer0_overflow(t0), .double_speed_mode(dsm),
    .cpu_idle(idle), .module_event_set(mev), .module_pin_out(mpo),
    .module_pin_oe(mpoe), .module_pin_in(mpi), .count_value(cnt),
    .count_tick(tick), .module4_watchdog_enable(wde),
    .p1_in({pins[7:3], ext, pins[1:0]}), .gpio_out(gout),
    .gpio_oe(goe), .p1_out(p1o), .p1_oe(p1e), .irq(irq));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w,
             paddr: {2'h0, idx, 2'h0}, pwdata: {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 8'h0);
    chk(q, e);
  endtask

  // Counts advanced over n clocks after a settle time
  task automatic rate(input int n, input logic [31:0] e);
    int k;
    k = 0;
    repeat (24) @(posedge clk);
    c0 = cnt;
    repeat (n) begin
      @(posedge clk);
      if (tick === 1'b1) k++;
    end
    chk(32'(16'(cnt - c0)), e);
    chk(32'(k), e);
  endtask

  task automatic results;
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    fails++;
    results();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`CATB_IDX_CTRL_FLAGS, 32'h0);
    rd(`CATB_IDX_MODE_CFG, 32'h0);
    rd(`CATB_IDX_COUNT_HI, 32'h0);
    rd(`CATB_IDX_COUNT_LO, 32'h0);
    apb(1'b0, 8'h10, 8'h0);
    chk({31'h0, er}, 32'h1);
    wr(`CATB_IDX_CTRL_FLAGS, 8'h40);
    for (int s = 0; s < 2; s++) begin
      for (int ds = 0; ds < 2; ds++) begin
        dsm <= ds[0];
        wr(`CATB_IDX_MODE_CFG, {6'h0, s[0], 1'b0});
        rate(120, 32'(120 / (s ? (ds ? `CATB_DIV_FAST_DS : `CATB_DIV_FAST)
          : (ds ? `CATB_DIV_SLOW_DS : `CATB_DIV_SLOW))));
      end
    end
    dsm <= 1'b0;
    wr(`CATB_IDX_CTRL_FLAGS, 8'h0);
    rate(120, 32'h0);
    rd(`CATB_IDX_COUNT_LO, {24'h0, cnt[7:0]});
    rd(`CATB_IDX_COUNT_HI, {24'h0, cnt[15:8]});
    wr(`CATB_IDX_CTRL_FLAGS, 8'h40);
    for (int e = 0; e < 2; e++) begin
      wr(`CATB_IDX_MODE_CFG, {5'h0, 1'b1, e[0], 1'b0});
      repeat (8) @(posedge clk);
      c0 = cnt;
      i_catb_pin_model.burst(e[0], 5, 4 + 3 * e);
      repeat (8) @(posedge clk);
      chk(32'(16'(cnt - c0)), 32'h5);
    end
    idle <= 1'b1;
    wr(`CATB_IDX_MODE_CFG, 8'h80);
    rate(120, 32'h0);
    wr(`CATB_IDX_MODE_CFG, 8'h40);
    rate(120, 32'ha);
    chk({31'h0, wde}, 32'h1);
    idle <= 1'b0;
    wr(`CATB_IDX_MODE_CFG, 8'h01);
    wr(`CATB_IDX_CTRL_FLAGS, 8'hc0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(`CATB_IDX_IRQ_STATUS, 32'h20);
    wr(`CATB_IDX_MODE_CFG, 8'h00);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(`CATB_IDX_CTRL_FLAGS, 8'h40);
    rd(`CATB_IDX_CTRL_FLAGS, 32'h40);
    wr(`CATB_IDX_IRQ_ENABLE, 8'h01);
    mev <= 5'h12;
    @(posedge clk);
    mev <= 5'h0;
    rd(`CATB_IDX_CTRL_FLAGS, 32'h52);
    chk({31'h0, irq}, 32'h0);
    mev <= 5'h01;
    @(posedge clk);
    mev <= 5'h0;
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(`CATB_IDX_IRQ_CLEAR, 8'h13);
    rd(`CATB_IDX_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    mpo <= 5'h15;
    mpoe <= 5'h1f;
    gout <= 8'h04;
    goe <= 8'h07;
    pins <= 8'h58;
    repeat (3) @(posedge clk);
    chk({16'h0, p1o, p1e}, 32'hacff);
    chk({27'h0, mpi}, 32'h0b);
    mpoe <= 5'h0;
    repeat (3) @(posedge clk);
    chk({16'h0, p1o, p1e}, 32'h0407);
    results();
  end
endmodule
